// ---- design/boot_option_word_loader.sv ----
// boot option word loader: fetches three option words from flash after
// every system reset, mirrors them read-only and drives the configured units
// assumes a flash that answers each read with an ack and holds data with it
`include "boot_option_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module boot_option_word_loader
    import boot_option_pkg::*;
#(
    parameter bit MEM_IS_32K = 1'b1
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_byte,
    output logic      [15:0] reg_rdata,
    // flash read port
    output logic             flash_rd_req,
    output logic      [15:0] flash_addr,
    input  wire logic        flash_ack,
    input  wire logic [15:0] flash_rdata,
    // debugger and cpu reset events
    input  wire logic        dbg_attached,
    input  wire logic        cpu_brk_reset,
    // configured units
    output logic             init_error_flag,
    output logic             rom_guard_reset_en,
    output logic             remap_disable,
    output logic             dog_run_en,
    output logic             dog_halt_run_en,
    output logic             trace_off,
    output logic             trace_ram_reserved,
    output logic      [15:0] data_ram_base,
    output logic             id_extension_bit0,
    output logic             boot_remap_src_sel,
    output logic      [15:0] remap_address_reg,
    output logic             boot_start_valid,
    output logic      [15:0] boot_start_addr,
    output logic      [2:0]  boot_start_seg
);

    ////////////////////////////////////////////////////////////////////////
    // reset release

    // rst_b clears both flops at once; release reaches logic 2 edges on
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // word index of a mirror address, 3 when not a mirror
    function automatic logic [1:0] mirror_index(input logic [15:0] a);
        logic [15:0] w;
        w = {a[15:1], 1'b0};
        if (w == `REG_OPT_WORD0)
            mirror_index = 2'd0;
        else if (w == `REG_OPT_WORD1)
            mirror_index = 2'd1;
        else if (w == `REG_OPT_WORD2)
            mirror_index = 2'd2;
        else
            mirror_index = 2'd3;
    endfunction

    // remap register value implied by option word 2
    function automatic logic [15:0] remap_from_opt(input logic [15:0] w2);
        logic [15:0] v;
        v = `REMAP_ADDR_RESET;
        if (!w2[`W2_SRC_SEL_BIT])
        begin
            v[`RA_ADDR_HI:`RA_ADDR_LO] = w2[`W2_ADDR_HI:`W2_ADDR_LO];
            v[`RA_SEG_HI:`RA_SEG_LO]   = w2[`W2_SEG_HI:`W2_SEG_LO];
        end
        remap_from_opt = v;
    endfunction

    // true when byte address a falls in the word at even address r
    function automatic logic is_word_at(input logic [15:0] a,
                                        input logic [15:0] r);
        is_word_at = ({a[15:1], 1'b0} == r);
    endfunction

    // start address of a remap register value, low address bits zero
    function automatic logic [15:0] start_of_remap(input logic [15:0] ra);
        start_of_remap = {ra[`RA_ADDR_HI:`RA_ADDR_LO], 12'h000};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // load sequencer

    load_state_t state_q;
    logic [1:0]  word_idx_q;
    word_t       opt_q [0:`OPT_WORD_COUNT-1];
    logic [15:0] area_base;
    logic        last_word;

    assign area_base = MEM_IS_32K ? `OPT_AREA_32K_W0
                                  : `OPT_AREA_16K_W0;
    assign last_word = (word_idx_q == 2'(`OPT_WORD_COUNT - 1));

    // one request per option word, words in ascending order
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q    <= LD_REQ;
            word_idx_q <= 2'd0;
        end
        else
        begin
            case (state_q)
                LD_REQ:
                begin
                    state_q <= LD_WAIT;
                end
                LD_WAIT:
                begin
                    if (flash_ack)
                    begin
                        if (last_word)
                            state_q <= LD_DONE;
                        else
                        begin
                            word_idx_q <= word_idx_q + 2'd1;
                            state_q    <= LD_REQ;
                        end
                    end
                end
                LD_DONE:
                begin
                    state_q <= LD_DONE;
                end
                default:
                begin
                    state_q <= LD_REQ;
                end
            endcase
        end
    end

    // option words start at blank value; flash ffff gives the same defaults
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            for (int i = 0; i < `OPT_WORD_COUNT; i++)
                opt_q[i] <= `OPT_WORD_RESET;
        end
        else if (state_q == LD_WAIT && flash_ack)
        begin
            opt_q[word_idx_q] <= flash_rdata;
        end
    end

    // request stands until the ack edge, then one idle cycle
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            flash_rd_req <= 1'b0;
            flash_addr   <= 16'h0000;
        end
        else if (state_q == LD_REQ)
        begin
            flash_rd_req <= 1'b1;
            flash_addr   <= area_base
                            + {13'd0, word_idx_q, 1'b0};
        end
        else if (flash_ack)
        begin
            flash_rd_req <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration outputs, taken once the load has finished

    logic loaded;
    logic trace_claim;
    assign loaded      = (state_q == LD_DONE);
    assign trace_claim = !trace_off && dbg_attached;

    // until the load ends every unit holds its safe default
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            init_error_flag    <= 1'b1;
            rom_guard_reset_en <= 1'b0;
            remap_disable      <= 1'b1;
            dog_run_en         <= 1'b0;
            dog_halt_run_en    <= 1'b0;
            trace_off          <= 1'b1;
            boot_remap_src_sel <= 1'b1;
        end
        else
        begin
            init_error_flag    <= !loaded;
            rom_guard_reset_en <= loaded
                                  && opt_q[0][`W0_ROM_GUARD_BIT];
            remap_disable      <= !loaded
                                  || opt_q[0][`W0_REMAP_DIS_BIT];
            dog_run_en         <= loaded
                                  && opt_q[0][`W0_DOG_RUN_BIT];
            dog_halt_run_en    <= loaded && opt_q[0][`W0_DOG_RUN_BIT]
                                  && opt_q[0][`W0_DOG_HALT_BIT];
            trace_off          <= !loaded
                                  || opt_q[1][`W1_TRACE_OFF_BIT];
            boot_remap_src_sel <= !loaded
                                  || opt_q[2][`W2_SRC_SEL_BIT];
        end
    end

    // trace claims ram only while a debugger is attached
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            trace_ram_reserved <= 1'b0;
            data_ram_base      <= `RAM_BASE_FULL;
            id_extension_bit0  <= 1'b0;
        end
        else
        begin
            trace_ram_reserved <= trace_claim;
            data_ram_base      <= trace_claim
                                  ? `RAM_BASE_TRACE
                                  : `RAM_BASE_FULL;
            id_extension_bit0  <= !trace_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // remap address register and start address

    logic        load_fin;
    logic        ra_wr;
    logic [15:0] opt_remap;

    assign load_fin  = (state_q == LD_WAIT) && flash_ack && last_word;
    assign ra_wr     = reg_wr && is_word_at(reg_addr, `REG_REMAP_ADDR);
    // remap value carried by the option word arriving on the last ack
    assign opt_remap = remap_from_opt(flash_rdata);

    // reset value comes from option word 2; load wins over a software write
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            remap_address_reg <= `REMAP_ADDR_RESET;
        else if (load_fin)
            remap_address_reg <= opt_remap;
        else if (ra_wr)
            remap_address_reg <= reg_wdata & `RA_WRITE_MASK;
    end

    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            boot_start_valid <= 1'b0;
            boot_start_addr  <= `BOOT_ADDR_DEFAULT;
            boot_start_seg   <= 3'd0;
        end
        else if (load_fin)
        begin
            boot_start_valid <= 1'b1;
            if (opt_q[0][`W0_REMAP_DIS_BIT])
            begin
                boot_start_addr <= `BOOT_ADDR_DEFAULT;
                boot_start_seg  <= 3'd0;
            end
            else
            begin
                boot_start_addr <= start_of_remap(opt_remap);
                boot_start_seg  <= opt_remap[`RA_SEG_HI:`RA_SEG_LO];
            end
        end
        else if (cpu_brk_reset && loaded)
        begin
            if (remap_disable)
            begin
                boot_start_addr <= `BOOT_ADDR_DEFAULT;
                boot_start_seg  <= 3'd0;
            end
            else
            begin
                // break reset follows the live remap register
                boot_start_addr <= start_of_remap(remap_address_reg);
                boot_start_seg  <= remap_address_reg[`RA_SEG_HI:`RA_SEG_LO];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read port, one cycle latency; mirrors ignore writes

    // status and remap words sit beside the three mirrors
    logic [15:0] rd_word;
    logic [1:0]  rd_idx;

    always_comb
    begin
        rd_idx  = mirror_index(reg_addr);
        rd_word = 16'h0000;
        if (rd_idx != 2'd3)
            rd_word = opt_q[rd_idx];
        else if (is_word_at(reg_addr, `REG_LOADER_STAT))
        begin
            rd_word[`ST_INIT_BIT]   = init_error_flag;
            rd_word[`ST_ID_EXT_BIT] = id_extension_bit0;
        end
        else if (is_word_at(reg_addr, `REG_REMAP_ADDR))
            rd_word = remap_address_reg;
    end

    // byte reads return the addressed half in the low byte
    always_ff @(posedge ref_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            reg_rdata <= 16'h0000;
        else if (reg_rd && reg_byte)
            reg_rdata <= {8'h00, reg_addr[0] ? rd_word[15:8]
                                             : rd_word[7:0]};
        else if (reg_rd)
            reg_rdata <= rd_word;
        else
            reg_rdata <= 16'h0000;
    end

endmodule // boot_option_word_loader

`default_nettype wire

// ---- design/boot_option_cfg.svh ----
// constants for the boot option word loader: offsets, fields, resets
// assumes a 16-bit register port and a 16-bit word-wide flash read port
`ifndef BOOT_OPTION_CFG_SVH
`define BOOT_OPTION_CFG_SVH

// option area word addresses, segment 0
`define OPT_AREA_16K_W0    16'h3FD8
`define OPT_AREA_32K_W0    16'h7FD8
`define OPT_WORD_STRIDE    16'h0002

// register offsets
`define REG_OPT_WORD0      16'hF920
`define REG_OPT_WORD1      16'hF922
`define REG_OPT_WORD2      16'hF924
`define REG_LOADER_STAT    16'hF926
`define REG_REMAP_ADDR     16'hF928

// reset values
`define OPT_WORD_RESET     16'hFFFF
`define REMAP_ADDR_RESET   16'h0000
`define BOOT_ADDR_DEFAULT  16'h0000

// option word 0 fields
`define W0_DOG_RUN_BIT     0
`define W0_DOG_HALT_BIT    2
`define W0_REMAP_DIS_BIT   8
`define W0_ROM_GUARD_BIT   12
// option word 1 fields
`define W1_TRACE_OFF_BIT   7
// option word 2 fields
`define W2_SRC_SEL_BIT     15
`define W2_SEG_HI          14
`define W2_SEG_LO          12
`define W2_ADDR_HI         11
`define W2_ADDR_LO         8

// remap address register layout
`define RA_ADDR_HI         15
`define RA_ADDR_LO         12
`define RA_SEG_HI          2
`define RA_SEG_LO          0
`define RA_WRITE_MASK      16'hF007

// loader status register fields
`define ST_INIT_BIT        0
`define ST_ID_EXT_BIT      1

// data ram windows
`define RAM_BASE_FULL      16'hE800
`define RAM_BASE_TRACE     16'hEC00

`define OPT_WORD_COUNT     3

`endif

// ---- design/boot_option_pkg.sv ----
// types for the boot option word loader
// assumes boot_option_cfg.svh holds all numeric constants
package boot_option_pkg;

    typedef enum logic [1:0]
    {
        LD_REQ  = 2'b00,
        LD_WAIT = 2'b01,
        LD_DONE = 2'b10
    } load_state_t;

    typedef logic [15:0] word_t;

endpackage

// ---- tb/boot_loader_checker.sv ----
// port checker for the boot option word loader
// assumes it is bound into the loader and sees its ports only
`include "boot_option_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module boot_loader_checker #(
    parameter bit MEM_IS_32K = 1'b1
)
(
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        flash_rd_req,
    input wire logic [15:0] flash_addr,
    input wire logic        flash_ack,
    input wire logic        dbg_attached,
    input wire logic        cpu_brk_reset,
    input wire logic        init_error_flag,
    input wire logic        remap_disable,
    input wire logic        dog_run_en,
    input wire logic        dog_halt_run_en,
    input wire logic        trace_off,
    input wire logic        trace_ram_reserved,
    input wire logic [15:0] data_ram_base,
    input wire logic [15:0] remap_address_reg,
    input wire logic [15:0] boot_start_addr
);
    localparam logic [15:0] BASE = MEM_IS_32K ? `OPT_AREA_32K_W0
                                              : `OPT_AREA_16K_W0;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    // a gap cycle, then the next option word is requested
    sequence s_next(logic [15:0] a);
        !flash_rd_req ##1 (flash_rd_req && flash_addr == a);
    endsequence

    a_req_holds: assert property (flash_rd_req && !flash_ack |=>
        flash_rd_req && $stable(flash_addr)) else $error("request dropped");
    a_load_first: assert property (flash_rd_req && flash_ack
        && flash_addr == BASE |=> s_next(BASE + 16'h0002))
        else $error("word 1 not fetched after word 0");
    a_load_last: assert property (flash_rd_req && flash_ack
        && flash_addr == BASE + 16'h0002 |=> s_next(BASE + 16'h0004))
        else $error("word 2 not fetched after word 1");
    a_rdata_pulse: assert property (reg_rdata != 16'h0000
        |-> $past(reg_rd)) else $error("read data without read");
    a_init_falls: assert property ($fell(init_error_flag)
        |-> $past(flash_ack) || $past(flash_ack, 2))
        else $error("init flag cleared without load");
    a_init_stays: assert property (!init_error_flag |=>
        !init_error_flag) else $error("init flag set again");
    a_dog_gate: assert property (dog_halt_run_en |-> dog_run_en)
        else $error("halt run without watchdog");
    a_trace_cause: assert property (trace_ram_reserved |->
        $past(dbg_attached) && !$past(trace_off))
        else $error("trace ram reserved without cause");
    a_ram_base: assert property ($past(dbg_attached)
        && !$past(trace_off) |-> trace_ram_reserved
        && data_ram_base == 16'hEC00) else $error("ram base wrong");
    a_brk_start: assert property (cpu_brk_reset && !init_error_flag
        |=> boot_start_addr == ($past(remap_disable) ? 16'h0000
        : $past(remap_address_reg) & 16'hF000))
        else $error("break start address wrong");
endmodule // boot_loader_checker

bind boot_option_word_loader boot_loader_checker #(
    .MEM_IS_32K(MEM_IS_32K)) u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_rd_req(flash_rd_req),
    .flash_addr(flash_addr), .flash_ack(flash_ack),
    .dbg_attached(dbg_attached), .cpu_brk_reset(cpu_brk_reset),
    .init_error_flag(init_error_flag), .remap_disable(remap_disable),
    .dog_run_en(dog_run_en), .dog_halt_run_en(dog_halt_run_en),
    .trace_off(trace_off), .trace_ram_reserved(trace_ram_reserved),
    .data_ram_base(data_ram_base), .remap_address_reg(remap_address_reg),
    .boot_start_addr(boot_start_addr));
`default_nettype wire

// ---- tb/flash_option_model.sv ----
// flash array model holding the three option words of a 32 KB part
// assumes one request at a time, answered after ack_dly wait cycles
`timescale 1ns/1ps
`default_nettype none
module flash_option_model (
    input  wire logic        ref_clk,
    input  wire logic        flash_rd_req,
    input  wire logic [15:0] flash_addr,
    input  wire logic [3:0]  ack_dly,
    input  wire logic [15:0] opt_w0,
    input  wire logic [15:0] opt_w1,
    input  wire logic [15:0] opt_w2,
    output logic             flash_ack,
    output logic      [15:0] flash_rdata
);
    logic [3:0]  wait_q;
    logic [15:0] word_d;
    // wrong address reads as zero, never as a blank word
    always_comb
    begin
        case (flash_addr)
            16'h7FD8: word_d = opt_w0;
            16'h7FDA: word_d = opt_w1;
            16'h7FDC: word_d = opt_w2;
            default:  word_d = 16'h0000;
        endcase
    end
    initial
    begin
        flash_ack   = 1'b0;
        flash_rdata = 16'h0000;
        wait_q      = 4'h0;
    end
    // data is valid in the ack cycle only, scrambled otherwise
    always @(posedge ref_clk)
    begin
        if (flash_rd_req && !flash_ack && wait_q >= ack_dly)
        begin
            flash_ack   <= 1'b1;
            flash_rdata <= word_d;
            wait_q      <= 4'h0;
        end
        else
        begin
            flash_ack   <= 1'b0;
            flash_rdata <= ~flash_rdata;
            if (flash_rd_req && !flash_ack)
                wait_q <= wait_q + 4'h1;
        end
    end
endmodule // flash_option_model
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the boot option word loader
// assumes the 32 KB option area and the flash model beside the loader
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import boot_option_pkg::*;
    logic        ref_clk, rst_b, reg_wr, reg_rd, reg_byte, flash_ack;
    logic        dbg_attached, cpu_brk_reset, flash_rd_req, init_error_flag;
    logic        rom_guard_reset_en, remap_disable, dog_run_en, trace_off;
    logic        dog_halt_run_en, trace_ram_reserved, id_extension_bit0;
    logic        boot_remap_src_sel, boot_start_valid;
    logic [2:0]  boot_start_seg;
    logic [3:0]  ack_dly;
    word_t       reg_addr, reg_wdata, reg_rdata, flash_addr, flash_rdata;
    word_t       data_ram_base, remap_address_reg, boot_start_addr;
    word_t       opt_w0, opt_w1, opt_w2;
    int          error_cnt, n_tests, cyc;

    boot_option_word_loader #(.MEM_IS_32K(1'b1)) dut (.ref_clk(ref_clk),
        .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_byte(reg_byte),
        .reg_rdata(reg_rdata), .flash_rd_req(flash_rd_req),
        .flash_addr(flash_addr), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata), .dbg_attached(dbg_attached),
        .cpu_brk_reset(cpu_brk_reset), .init_error_flag(init_error_flag),
        .rom_guard_reset_en(rom_guard_reset_en),
        .remap_disable(remap_disable), .dog_run_en(dog_run_en),
        .dog_halt_run_en(dog_halt_run_en), .trace_off(trace_off),
        .trace_ram_reserved(trace_ram_reserved),
        .data_ram_base(data_ram_base), .id_extension_bit0(id_extension_bit0),
        .boot_remap_src_sel(boot_remap_src_sel),
        .remap_address_reg(remap_address_reg),
        .boot_start_valid(boot_start_valid),
        .boot_start_addr(boot_start_addr), .boot_start_seg(boot_start_seg));
    flash_option_model flash (.ref_clk(ref_clk), .flash_rd_req(flash_rd_req),
        .flash_addr(flash_addr), .ack_dly(ack_dly), .opt_w0(opt_w0),
        .opt_w1(opt_w1), .opt_w2(opt_w2), .flash_ack(flash_ack),
        .flash_rdata(flash_rdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input word_t seen, input word_t exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input word_t a, input logic b, input word_t exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        reg_byte <= b;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask
    task automatic wr(input word_t a, input word_t d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic brk(input word_t exp_addr, input logic [2:0] exp_seg);
        @(posedge ref_clk);
        cpu_brk_reset <= 1'b1;
        @(posedge ref_clk);
        cpu_brk_reset <= 1'b0;
        @(posedge ref_clk);
        #1 check(boot_start_addr, exp_addr);
        check(16'(boot_start_seg), 16'(exp_seg));
    endtask
    // reset with new flash contents, wait for the load, judge every configured unit output
    task automatic boot(input word_t w0, w1, w2, input logic [3:0] dly);
        int   n;
        word_t ra;
        @(posedge ref_clk);
        opt_w0  <= w0;
        opt_w1  <= w1;
        opt_w2  <= w2;
        ack_dly <= dly;
        rst_b   <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        n = 0;
        while (init_error_flag !== 1'b0 && n < 200)
        begin
            @(posedge ref_clk);
            n++;
        end
        repeat (2) @(posedge ref_clk);
        #1 check(16'(init_error_flag), 16'h0000);
        ra = w2[15] ? 16'h0000 : {w2[11:8], 9'h000, w2[14:12]};
        check(16'({rom_guard_reset_en, remap_disable, dog_run_en,
            dog_halt_run_en}),
            16'({w0[12], w0[8], w0[0], w0[2] & w0[0]}));
        check(16'({trace_off, id_extension_bit0, trace_ram_reserved}),
            16'({w1[7], !w1[7], !w1[7] & dbg_attached}));
        check(data_ram_base, (!w1[7] && dbg_attached) ? 16'hEC00
            : 16'hE800);
        check(remap_address_reg, ra);
        check(16'({boot_start_valid, boot_remap_src_sel}),
            16'({1'b1, w2[15]}));
        check(boot_start_addr, w0[8] ? 16'h0000 : ra & 16'hF000);
        check(16'(boot_start_seg), w0[8] ? 16'h0000 : 16'(ra[2:0]));
        rdc(16'hF920, 1'b0, w0);
        rdc(16'hF922, 1'b0, w1);
        rdc(16'hF924, 1'b0, w2);
        rdc(16'hF926, 1'b0, {14'h0000, !w1[7], 1'b0});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_blank();
        dbg_attached <= 1'b1;
        boot(16'hFFFF, 16'hFFFF, 16'hFFFF, 4'h0);
    endtask
    task automatic test_example();
        dbg_attached <= 1'b1;
        boot(16'hEEFE, 16'hFF7F, 16'h0DFF, 4'h5);
        rdc(16'hF921, 1'b1, 16'h00EE);
        rdc(16'hF920, 1'b1, 16'h00FE);
        wr(16'hF920, 16'h0000);
        rdc(16'hF920, 1'b0, 16'hEEFE);
        rdc(16'hF930, 1'b0, 16'h0000);
        @(posedge ref_clk);
        opt_w0 <= 16'hFFFF;
        rdc(16'hF920, 1'b0, 16'hEEFE);
        brk(16'hD000, 3'h0);
        wr(16'hF928, 16'h2231);
        brk(16'h2000, 3'h1);
    endtask
    task automatic test_halt_gate();
        dbg_attached <= 1'b0;
        boot(16'hFEFE, 16'hFFFF, 16'h8DFF, 4'h2);
    endtask
    task automatic test_remap_off();
        dbg_attached <= 1'b0;
        boot(16'hFFFF, 16'hFF7F, 16'h0DFF, 4'h1);
        wr(16'hF928, 16'h3001);
        brk(16'h0000, 3'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    initial
    begin
        {reg_wr, reg_rd, reg_byte, cpu_brk_reset, dbg_attached} = 5'h00;
        {reg_addr, reg_wdata, ack_dly} = 36'h0_0000_0000;
        {opt_w0, opt_w1, opt_w2} = 48'hFFFF_FFFF_FFFF;
        {error_cnt, n_tests, cyc} = 96'h0;
        rst_b = 1'b0;
        repeat (3) @(posedge ref_clk);
        test_blank();
        test_example();
        test_halt_gate();
        test_remap_off();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
